/* lineif_tx_config_regs.sv */
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "lineif_tx_map.svh"

module lineif_tx_config_regs
    import lineif_tx_pkg::*;
#(
    parameter int NUM_CH = 9,
    parameter int OC_CYCLES = `TXC_OC_TIME_MS * `TXC_CLK_HZ / 1000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [12:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // channel mode and line status
    input wire logic [NUM_CH-1:0] e1_mode_i,
    input wire logic [NUM_CH-1:0] tx_overcurrent_i,
    // framer system side
    input wire logic [NUM_CH-1:0] tx_clock_pin_i,
    input wire logic [NUM_CH-1:0] tx_data_pin_i,
    input wire logic [NUM_CH-1:0] tx_positive_rail_pin_i,
    input wire logic [NUM_CH-1:0] tx_negative_rail_pin_i,
    // indication sources
    input wire logic [NUM_CH-1:0] prbs_to_tx_i,
    input wire logic [NUM_CH-1:0] arbitrary_pattern_i,
    input wire logic [NUM_CH-1:0] sys_alarm_indication_i,
    input wire logic [NUM_CH-1:0] tx_loss_of_signal_i,
    input wire logic [NUM_CH-1:0] sys_excess_zeros_i,
    input wire logic [NUM_CH-1:0] sys_bipolar_violation_i,
    input wire logic [NUM_CH-1:0] sys_loss_of_signal_i,
    // line driver control
    output logic [NUM_CH-1:0] line_tip_oe_o,
    output logic [NUM_CH-1:0] line_ring_oe_o,
    output logic [NUM_CH-1:0] current_limit_o,
    output logic [NUM_CH-1:0] tx_power_down_o,
    // sampled transmit data and indication
    output logic [NUM_CH-1:0] tx_pos_data_o,
    output logic [NUM_CH-1:0] tx_neg_data_o,
    output logic [NUM_CH-1:0] tx_multifunction_pin_o,
    // encoder and pulse shaping control
    output logic [NUM_CH*3-1:0] tx_impedance_select_o,
    output logic [NUM_CH-1:0] b8zs_enable_o,
    output logic [NUM_CH-1:0] hdb3_enable_o,
    output logic [NUM_CH*4-1:0] waveform_template_select_o,
    output logic [NUM_CH-1:0] arb_waveform_enable_o
);

    if (NUM_CH < 1 || NUM_CH > 9) begin : g_bad_ch
        $error("NUM_CH must lie between 1 and 9");
    end
    if (OC_CYCLES < 1) begin : g_bad_oc
        $error("OC_CYCLES must be at least 1");
    end

    // bank number to channel: ch0 has its own bank, ch1..8 in order
    function automatic logic [3:0] bank_to_ch(input logic [4:0] bank);
        if (bank == `TXC_CH0_BANK) begin
            return 4'h0;
        end
        return 4'(bank - `TXC_CH1_BANK + 5'h01);
    endfunction

    function automatic logic mf_pick(input logic [2:0] code, input logic [1:0] mode,
                                     input logic to_tx, input logic pat, input logic ais,
                                     input logic tx_loss_of_signal, input logic exz, input logic bpv,
                                     input logic sys_loss_of_signal);
        logic rz;
        rz = (mode == SYS_DUAL_RZ);
        case (code)
            MF_PATTERN: return to_tx & pat;
            MF_ALARM: return ais;
            MF_TX_LOS: return tx_loss_of_signal;
            MF_EXZ: return exz;
            MF_BPV: return rz & bpv;
            MF_EXZ_BPV: return rz & (exz | bpv);
            MF_SYS_LOS: return rz & sys_loss_of_signal;
            default: return 1'b0;
        endcase
    endfunction

    // address decode
    wire logic [10:0] word_idx = wb_adr_i[12:2];
    wire logic [4:0] bank = word_idx[10:6];
    wire logic [5:0] reg_idx = word_idx[5:0];
    wire logic [3:0] acc_ch = bank_to_ch(bank);
    wire logic bank_hit = (bank == `TXC_CH0_BANK) || (bank < 5'(NUM_CH - 1));
    wire logic sel_ldc = (reg_idx == `TXC_LDC_IDX);
    wire logic sel_sic = (reg_idx == `TXC_SIC_IDX);
    wire logic sel_wts = (reg_idx == `TXC_WTS_IDX);
    wire logic mapped = bank_hit && (sel_ldc || sel_sic || sel_wts);
    wire logic req = wb_cyc_i && wb_stb_i;
    wire logic take = req && !wb_ack_o;
    wire logic wr_en = take && wb_we_i && wb_sel_i[0] && mapped;

    logic [7:0] ldc_reg [NUM_CH];
    logic [7:0] sic_reg [NUM_CH];
    logic [7:0] wts_reg [NUM_CH];

    wire logic [7:0] ldc_next = wb_dat_i[7:0] & `TXC_LDC_MASK;
    wire logic [7:0] sic_next = wb_dat_i[7:0] & `TXC_SIC_MASK;
    wire logic [7:0] wts_next = wb_dat_i[7:0] & `TXC_WTS_MASK;

    wire logic [7:0] rd_byte = !mapped ? 8'h00 :
                               sel_ldc ? ldc_reg[acc_ch] :
                               sel_sic ? sic_reg[acc_ch] : wts_reg[acc_ch];

    // bus answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= take;
            if (take) begin
                wb_dat_o <= {24'h000000, rd_byte};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (rst_i) begin
                ldc_reg[c] <= `TXC_LDC_RESET;
                sic_reg[c] <= `TXC_SIC_RESET;
                wts_reg[c] <= `TXC_WTS_RESET;
            end else if (wr_en && acc_ch == 4'(c)) begin
                if (sel_ldc) ldc_reg[c] <= ldc_next;
                if (sel_sic) sic_reg[c] <= sic_next;
                if (sel_wts) wts_reg[c] <= wts_next;
            end
        end
    end

    // per-channel field views
    logic [NUM_CH-1:0] drv_en, pwr_dn, oc_hz_sel, single_end;
    logic [NUM_CH-1:0] edge_rise, data_inv, ami_sel;
    logic [NUM_CH-1:0] oc_expired, sample_now;
    logic [1:0] sys_mode [NUM_CH];
    logic [2:0] mf_code [NUM_CH];
    logic [31:0] oc_cnt_reg [NUM_CH];
    logic [NUM_CH-1:0] tck_prev_reg;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign drv_en[c] = ldc_reg[c][`TXC_LDC_EN_BIT];
        assign pwr_dn[c] = ldc_reg[c][`TXC_LDC_PD_BIT];
        assign oc_hz_sel[c] = ldc_reg[c][`TXC_LDC_OCHZ_BIT];
        assign single_end[c] = ldc_reg[c][`TXC_LDC_SE_BIT];
        assign edge_rise[c] = sic_reg[c][`TXC_SIC_EDGE_BIT];
        assign data_inv[c] = sic_reg[c][`TXC_SIC_INV_BIT];
        assign ami_sel[c] = sic_reg[c][`TXC_SIC_AMI_BIT];
        assign sys_mode[c] = sic_reg[c][1:0];
        assign mf_code[c] = sic_reg[c][7:5];
        // overcurrent persisted past the limit time with tri-state selected
        assign oc_expired[c] = tx_overcurrent_i[c] && oc_hz_sel[c]
                               && oc_cnt_reg[c] >= 32'(OC_CYCLES);
        // active edge of the framer clock
        assign sample_now[c] = edge_rise[c] ? (tx_clock_pin_i[c] && !tck_prev_reg[c])
                                            : (!tx_clock_pin_i[c] && tck_prev_reg[c]);
        assign tx_impedance_select_o[c*3 +: 3] = ldc_reg[c][2:0];
        assign waveform_template_select_o[c*4 +: 4] = wts_reg[c][3:0];
        assign arb_waveform_enable_o[c] = wts_reg[c][`TXC_WTS_ARB_BIT];
        assign tx_power_down_o[c] = pwr_dn[c];
        // line code follows the channel mode unless AMI is selected
        assign b8zs_enable_o[c] = !ami_sel[c] && !e1_mode_i[c];
        assign hdb3_enable_o[c] = !ami_sel[c] && e1_mode_i[c];
    end

    // overcurrent timer, limiting runs while the condition lasts when tri-state is not selected, else until the limit time
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (rst_i || !tx_overcurrent_i[c]) begin
                oc_cnt_reg[c] <= 32'h00000000;
            end else if (oc_cnt_reg[c] < 32'(OC_CYCLES)) begin
                oc_cnt_reg[c] <= oc_cnt_reg[c] + 32'h00000001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_tip_oe_o <= '0;
            line_ring_oe_o <= '0;
            current_limit_o <= '0;
        end else begin
            line_tip_oe_o <= drv_en & ~pwr_dn & ~oc_expired;
            line_ring_oe_o <= drv_en & ~pwr_dn & ~oc_expired & ~single_end;
            current_limit_o <= tx_overcurrent_i & ~oc_expired;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tck_prev_reg <= '0;
            tx_pos_data_o <= '0;
            tx_neg_data_o <= '0;
        end else begin
            tck_prev_reg <= tx_clock_pin_i;
            for (int c = 0; c < NUM_CH; c++) begin
                if (pwr_dn[c]) begin
                    tx_pos_data_o[c] <= 1'b0;
                    tx_neg_data_o[c] <= 1'b0;
                end else if (sample_now[c]) begin
                    if (sys_mode[c] == SYS_SINGLE_NRZ) begin
                        tx_pos_data_o[c] <= tx_data_pin_i[c] ^ data_inv[c];
                        tx_neg_data_o[c] <= 1'b0;
                    end else begin
                        tx_pos_data_o[c] <= tx_positive_rail_pin_i[c] ^ data_inv[c];
                        tx_neg_data_o[c] <= tx_negative_rail_pin_i[c] ^ data_inv[c];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_multifunction_pin_o <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                tx_multifunction_pin_o[c] <=
                    (sys_mode[c] == SYS_SINGLE_NRZ || sys_mode[c] == SYS_DUAL_RZ)
                    && mf_pick(mf_code[c], sys_mode[c], prbs_to_tx_i[c],
                               arbitrary_pattern_i[c], sys_alarm_indication_i[c],
                               tx_loss_of_signal_i[c], sys_excess_zeros_i[c],
                               sys_bipolar_violation_i[c], sys_loss_of_signal_i[c]);
            end
        end
    end

    // checks on the bus answer and on channel 0
    chk_ack_one_cycle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        take |=> wb_ack_o ##1 !wb_ack_o
    ) else $error("ack not a single cycle after request");

    chk_reserved_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000 && !ldc_reg[0][7] && wts_reg[0][7:4] == 4'h0
    ) else $error("reserved bits not zero");

    chk_ch0_bank_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (take && wb_we_i && wb_sel_i[0] && bank == `TXC_CH0_BANK && sel_ldc)
        |=> ldc_reg[0] == ($past(wb_dat_i[7:0]) & `TXC_LDC_MASK)
    ) else $error("channel 0 bank write lost");

    chk_driver_off: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !drv_en[0] |=> !line_tip_oe_o[0] && !line_ring_oe_o[0]
    ) else $error("line driven while disabled");

    chk_power_down: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pwr_dn[0] |=> !line_tip_oe_o[0] && !tx_pos_data_o[0] && !tx_neg_data_o[0]
    ) else $error("powered-down channel still active");

    chk_oc_tristate: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (tx_overcurrent_i[0] && oc_hz_sel[0] && oc_cnt_reg[0] >= 32'(OC_CYCLES))
        |=> !line_tip_oe_o[0] && !current_limit_o[0]
    ) else $error("overcurrent not tri-stated after limit time");

    chk_oc_limit_keep: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (tx_overcurrent_i[0] && !oc_hz_sel[0]) |=> current_limit_o[0]
    ) else $error("current limit dropped while selected");

    chk_single_ring: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (single_end[0] && drv_en[0] && !pwr_dn[0] && !oc_expired[0])
        |=> line_tip_oe_o[0] && !line_ring_oe_o[0]
    ) else $error("single-ended mode drives ring");

    chk_mf_gated: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sys_mode[0] == SYS_DUAL_NRZ |=> !tx_multifunction_pin_o[0]
    ) else $error("multifunction pin active in dual-rail NRZ");

    chk_mf_alarm: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (sys_mode[0] == SYS_SINGLE_NRZ && mf_code[0] == MF_ALARM)
        |=> tx_multifunction_pin_o[0] == $past(sys_alarm_indication_i[0])
    ) else $error("alarm indication not on multifunction pin");

    chk_mf_rz_only: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (sys_mode[0] == SYS_SINGLE_NRZ && mf_code[0] >= MF_BPV) |=> !tx_multifunction_pin_o[0]
    ) else $error("rz-only code active in single-rail mode");

    chk_sample_data: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (sample_now[0] && !pwr_dn[0] && sys_mode[0] == SYS_SINGLE_NRZ)
        |=> tx_pos_data_o[0] == ($past(tx_data_pin_i[0]) ^ $past(data_inv[0]))
    ) else $error("sampled data wrong");

    chk_line_code: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(b8zs_enable_o[0] && hdb3_enable_o[0]) && !(ami_sel[0] && (b8zs_enable_o[0] || hdb3_enable_o[0]))
    ) else $error("line code selection inconsistent");

endmodule // lineif_tx_config_regs

`default_nettype wire

/* lineif_tx_framer_model.sv */
`timescale 1ns/100ps
`default_nettype none

module lineif_tx_framer_model #(
    parameter int N = 9
) (
    // clock and control
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic rz_i,
    input wire logic [N-1:0] pat_i,
    // system side pins
    output logic [N-1:0] tx_clock_pin_o,
    output logic [N-1:0] tx_data_pin_o,
    output logic [N-1:0] tx_positive_rail_pin_o,
    output logic [N-1:0] tx_negative_rail_pin_o,
    output logic rise_o
);
    logic [2:0] cnt_reg = 3'h0;
    logic [N-1:0] dat_reg = '0;
    logic [N-1:0] idle_reg = '0;
    logic hi;

    // clock stands low between frames
    assign hi = run_i & cnt_reg[2];
    assign tx_clock_pin_o = {N{hi}};
    assign tx_data_pin_o = run_i ? dat_reg : idle_reg;
    assign tx_positive_rail_pin_o = run_i ? (dat_reg & {N{hi | !rz_i}}) : ~idle_reg;
    assign tx_negative_rail_pin_o = run_i ? (~dat_reg & {N{hi | !rz_i}}) : idle_reg;

    always_ff @(posedge clk_i) begin
        cnt_reg <= run_i ? cnt_reg + 3'h1 : 3'h0;
        idle_reg <= ~idle_reg;
        rise_o <= run_i && cnt_reg == 3'h3;
        if (run_i && cnt_reg == 3'h3) begin
            dat_reg <= pat_i;
        end
    end
endmodule // lineif_tx_framer_model

`default_nettype wire

/* lineif_tx_map.svh */
`ifndef LINEIF_TX_MAP_SVH
`define LINEIF_TX_MAP_SVH

// register index within a channel bank, byte address is four times the index
`define TXC_LDC_IDX 6'h04
`define TXC_SIC_IDX 6'h05
`define TXC_WTS_IDX 6'h06
// channel one bank starts at index 11'h000, banks are 11'h040 apart
`define TXC_CH1_BANK 5'h00
`define TXC_CH0_BANK 5'h1F
// write masks, reserved bits stay zero
`define TXC_LDC_MASK 8'h7F
`define TXC_SIC_MASK 8'hFF
`define TXC_WTS_MASK 8'h0F
// reset values
`define TXC_LDC_RESET 8'h00
`define TXC_SIC_RESET 8'h01
`define TXC_WTS_RESET 8'h02
// field positions
`define TXC_LDC_EN_BIT 6
`define TXC_LDC_PD_BIT 5
`define TXC_LDC_OCHZ_BIT 4
`define TXC_LDC_SE_BIT 3
`define TXC_SIC_EDGE_BIT 4
`define TXC_SIC_INV_BIT 3
`define TXC_SIC_AMI_BIT 2
`define TXC_WTS_ARB_BIT 3
// timing
`define TXC_OC_TIME_MS 1
`define TXC_CLK_HZ 20000000

`endif

/* lineif_tx_pkg.sv */
package lineif_tx_pkg;

    typedef enum logic [1:0] {
        SYS_SINGLE_NRZ = 2'h0,
        SYS_DUAL_NRZ = 2'h1,
        SYS_DUAL_RZ = 2'h2
    } sys_if_t;

    typedef enum logic [2:0] {
        MF_PATTERN = 3'h0,
        MF_ALARM = 3'h1,
        MF_TX_LOS = 3'h3,
        MF_EXZ = 3'h4,
        MF_BPV = 3'h5,
        MF_EXZ_BPV = 3'h6,
        MF_SYS_LOS = 3'h7
    } mf_code_t;

endpackage

/* tb_lineif_tx_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lineif_tx_map.svh"

module tb_lineif_tx_config_regs;
    import lineif_tx_pkg::*;
    localparam int NC = 9;
    localparam int OCC = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, run = 1'b0, rz = 1'b0, rise;
    logic [12:0] adr_r = '0;
    logic [3:0] sel = '0;
    logic [31:0] dat = '0, dat_o, seed = 32'hE315C1DA;
    logic [NC-1:0] e1 = '0, oc = '0, prbs = '0, pat = '0, ais = '0, tx_loss_of_signal = '0;
    logic [NC-1:0] exz = '0, bpv = '0, sys_loss_of_signal = '0, fpat = '0, fclk, fdat, fpos, fneg;
    logic [NC-1:0] tip, ring, clim, pd, pos, neg, mf, b8, hdb, arbitrary_pattern;
    logic [NC*3-1:0] imp;
    logic [NC*4-1:0] wts;
    int num_errors = 0, n_compared = 0, cycles = 0;
    int mdl[NC][3];
    int msk[3] = '{`TXC_LDC_MASK, `TXC_SIC_MASK, `TXC_WTS_MASK};
    int rstv[3] = '{`TXC_LDC_RESET, `TXC_SIC_RESET, `TXC_WTS_RESET};
    logic [7:0] tbl[4] = '{8'h40, 8'h48, 8'h60, 8'h00};

    lineif_tx_framer_model #(.N(NC)) i_framer (.clk_i(clk_i), .run_i(run), .rz_i(rz),
        .pat_i(fpat), .tx_clock_pin_o(fclk), .tx_data_pin_o(fdat),
        .tx_positive_rail_pin_o(fpos), .tx_negative_rail_pin_o(fneg), .rise_o(rise));

    lineif_tx_config_regs #(.NUM_CH(NC), .OC_CYCLES(OCC)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr_r), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .e1_mode_i(e1),
        .tx_overcurrent_i(oc), .tx_clock_pin_i(fclk), .tx_data_pin_i(fdat),
        .tx_positive_rail_pin_i(fpos), .tx_negative_rail_pin_i(fneg), .prbs_to_tx_i(prbs),
        .arbitrary_pattern_i(pat), .sys_alarm_indication_i(ais), .tx_loss_of_signal_i(tx_loss_of_signal),
        .sys_excess_zeros_i(exz), .sys_bipolar_violation_i(bpv),
        .sys_loss_of_signal_i(sys_loss_of_signal), .line_tip_oe_o(tip), .line_ring_oe_o(ring),
        .current_limit_o(clim), .tx_power_down_o(pd), .tx_pos_data_o(pos),
        .tx_neg_data_o(neg), .tx_multifunction_pin_o(mf), .tx_impedance_select_o(imp),
        .b8zs_enable_o(b8), .hdb3_enable_o(hdb), .waveform_template_select_o(wts),
        .arb_waveform_enable_o(arbitrary_pattern));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // cycle ceiling against hangs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    function automatic logic [31:0] rnd();
        repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [12:0] adr(input int c, input int r);
        return {(c == 0) ? `TXC_CH0_BANK : 5'(c - 1), 6'(`TXC_LDC_IDX + r), 2'h0};
    endfunction

    // classic single cycle, ack and read data taken at the rising edge
    task automatic wb(input logic w, input logic [12:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [7:0] q);
        int t;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr_r <= a;
        sel <= s;
        dat <= {24'h0, d};
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (ack !== 1'b1) chk(0, 1, "no ack");
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic nedge(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic rise_wait();
        int t;
        t = 0;
        do begin
            @(negedge clk_i);
            t++;
        end while (rise !== 1'b1 && t < 20);
        if (t >= 20) chk(0, 1, "framer clock");
    endtask

    function automatic logic mfx(input int code, input int mode);
        if (mode == 1) return 1'b0;
        case (code)
            MF_PATTERN: return prbs[1] & pat[1];
            MF_ALARM: return ais[1];
            MF_TX_LOS: return tx_loss_of_signal[1];
            MF_EXZ: return exz[1];
            MF_BPV: return mode == 2 && bpv[1];
            MF_EXZ_BPV: return mode == 2 && (exz[1] | bpv[1]);
            MF_SYS_LOS: return mode == 2 && sys_loss_of_signal[1];
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        int c, r, k, d;
        logic [31:0] v, w;
        logic [7:0] rd;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (c = 0; c < NC; c++) begin
            for (r = 0; r < 3; r++) begin
                mdl[c][r] = rstv[r];
                wb(1'b0, adr(c, r), 8'h00, 4'hF, rd);
                chk(rd, mdl[c][r], "reset value");
            end
        end
        chk(tip | ring, 0, "driver off at reset");
        wb(1'b1, 13'h0810, 8'h20, 4'hF, rd);
        wb(1'b0, 13'h0810, 8'h00, 4'hF, rd);
        chk(rd, 0, "absent bank");
        // a bank far above the channel banks must not alias channel 1
        wb(1'b1, 13'h1010, 8'h7F, 4'h1, rd);
        wb(1'b0, 13'h1010, 8'h00, 4'hF, rd);
        chk(rd, 0, "aliased bank");
        wb(1'b0, adr(1, 0), 8'h00, 4'hF, rd);
        chk(rd, mdl[1][0], "alias write leaked");
        wb(1'b0, adr(1, 3), 8'h00, 4'hF, rd);
        chk(rd, 0, "unmapped register");
        wb(1'b1, adr(2, 0), 8'h7F, 4'hE, rd);
        wb(1'b0, adr(2, 0), 8'h00, 4'hF, rd);
        chk(rd, 0, "low lane disabled");
        for (c = 0; c < NC; c++) begin
            for (r = 0; r < 3; r++) begin
                v = rnd();
                wb(1'b1, adr(c, r), v[7:0], 4'h1, rd);
                mdl[c][r] = v[7:0] & msk[r];
            end
        end
        for (c = 0; c < NC; c++) begin
            for (r = 0; r < 3; r++) begin
                wb(1'b0, adr(c, r), 8'h00, 4'hF, rd);
                chk(rd, mdl[c][r], "readback");
            end
            chk(imp[3*c+:3], mdl[c][0] & 7, "impedance");
            chk(wts[4*c+:4], mdl[c][2], "template");
            chk(arbitrary_pattern[c], mdl[c][2] >> 3, "arbitrary waveform");
        end
        for (k = 0; k < 4; k++) begin
            for (c = 0; c < NC; c++) wb(1'b1, adr(c, 0), tbl[(c + k) % 4], 4'h1, rd);
            nedge(3);
            for (c = 0; c < NC; c++) begin
                rd = tbl[(c + k) % 4];
                chk(tip[c], rd[6] & !rd[5], "tip enable");
                chk(ring[c], rd[6] & !rd[5] & !rd[3], "ring enable");
                chk(pd[c], rd[5], "power down");
            end
        end
        // channel 0 tri-states after the limit time, channel 3 keeps limiting
        wb(1'b1, adr(0, 0), 8'h50, 4'h1, rd);
        wb(1'b1, adr(3, 0), 8'h40, 4'h1, rd);
        @(posedge clk_i);
        oc <= 9'h009;
        nedge(3);
        chk({clim[3], clim[0], tip[3], tip[0]}, 4'hF, "early limiting");
        nedge(OCC + 3);
        chk({clim[3], clim[0], tip[3], tip[0]}, 4'hA, "timed tri-state");
        wb(1'b1, adr(0, 0), 8'h40, 4'h1, rd);
        nedge(2);
        chk({clim[0], tip[0]}, 2'h3, "limiting without tri-state");
        @(posedge clk_i);
        oc <= '0;
        wb(1'b1, adr(1, 0), 8'h40, 4'h1, rd);
        for (k = 0; k < 24; k++) begin
            v = rnd();
            w = rnd();
            d = ((k % 8) << 5) | (k / 8) | (v[2] << 2);
            wb(1'b1, adr(0, 1), d[7:0], 4'h1, rd);
            wb(1'b1, adr(1, 1), d[7:0], 4'h1, rd);
            {prbs, pat, ais} <= v[26:0];
            {tx_loss_of_signal, exz, bpv} <= w[26:0];
            sys_loss_of_signal <= v[31:23];
            e1 <= w[31:23];
            nedge(3);
            chk(mf[1], mfx(k % 8, k / 8), "indication");
            chk({b8[1], hdb[1]}, {!v[2] & !e1[1], !v[2] & e1[1]}, "line code");
        end
        @(posedge clk_i);
        run <= 1'b1;
        for (k = 0; k < 4; k++) begin
            v = rnd();
            d = ((k & 1) << 4) | (v[3] << 3) | (k >> 1);
            wb(1'b1, adr(0, 1), d[7:0], 4'h1, rd);
            wb(1'b1, adr(1, 1), d[7:0], 4'h1, rd);
            fpat <= v[NC-1:0];
            rise_wait();
            rise_wait();
            @(posedge clk_i);
            fpat <= ~v[NC-1:0];
            rise_wait();
            nedge(1);
            chk(pos[1], 1'((k[0] ? ~v[1] : v[1]) ^ v[3]), "active edge");
            nedge(4);
            chk({neg[1], pos[1]}, {(k > 1) & (v[1] ^ v[3]), ~v[1] ^ v[3]}, "rails");
        end
        print_verdict();
    end
endmodule // tb_lineif_tx_config_regs

`default_nettype wire
